// ===== bst_pkg.sv
package bst_pkg;

  // instruction register layout and codes
  localparam int         IR_W        = 3;
  localparam logic [2:0] INS_EXTEST  = 3'h0;
  localparam logic [2:0] INS_IDCODE  = 3'h1;
  localparam logic [2:0] INS_SAMPLE  = 3'h2;
  localparam logic [2:0] INS_CLAMP   = 3'h3;
  localparam logic [2:0] INS_HIGHZ   = 3'h4;
  localparam logic [2:0] INS_BYPASS  = 3'h7;

  // register lengths
  localparam int ID_W  = 32;
  localparam int BSR_W = 32;

  // identification code field positions and widths
  localparam int ID_REV_LSB   = 28;
  localparam int ID_REV_W     = 4;
  localparam int ID_PART_LSB  = 12;
  localparam int ID_PART_W    = 16;
  localparam int ID_MAKER_LSB = 0;
  localparam int ID_MAKER_W   = 12;

  // reset values
  localparam logic BYP_RST = 1'h0;
  localparam logic TDO_RST = 1'h0;

  // synchroniser depth for pin inputs
  localparam int SYNC_STAGES = 3;

  typedef logic [IR_W-1:0] bst_instr_t;

  // tap controller state flags, levels in the core clock domain
  typedef struct packed {
    logic tlr;         // test-logic-reset
    logic capture_dr;  // capture-dr
    logic shift_dr;    // shift-dr
    logic update_dr;   // update-dr
  } bst_tap_s;

  // active test data register, one-hot
  typedef enum logic [2:0] {
    SEL_BYP = 3'h1,
    SEL_ID  = 3'h2,
    SEL_BSR = 3'h4
  } bst_sel_e;

endpackage

// ===== bst_pin_sync.sv
`timescale 1ns/10ps
// three-stage pin synchroniser; output moves once stages two and three agree
module bst_pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         core_clk_i,
  input  wire logic         rstn_i,
  // asynchronous input and filtered level
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  initial
  begin
    if (W < 1) $error("bst_pin_sync: W must be at least one");
  end

  genvar gi;
  generate
    for (gi = 0; gi < W; gi++)
    begin : g_bit
      logic s1, s2, s3, q;              // stage flops and filtered level
      logic next_q;

      // level only follows once two stages agree, so a glitch is dropped
      always_comb
      begin
        next_q = (s2 == s3) ? s3 : q;
      end

      // s1 is read only by s2
      always_ff @(posedge core_clk_i or negedge rstn_i)
      begin
        if (!rstn_i)
        begin
          s1 <= 1'h0;
          s2 <= 1'h0;
          s3 <= 1'h0;
          q  <= 1'h0;
        end
        else
        begin
          s1 <= d_i[gi];
          s2 <= s1;
          s3 <= s2;
          q  <= next_q;
        end
      end

      assign q_o[gi] = q;
    end
  endgenerate

endmodule

// ===== bst_tdr.sv
`timescale 1ns/10ps
module bst_tdr #(
  parameter logic [3:0]  ID_REV   = 4'h0,    // arbitrary value
  parameter logic [15:0] ID_PART  = 16'h0001, // arbitrary value
  parameter logic [11:0] ID_MAKER = 12'h001,  // arbitrary value
  parameter int          BSR_W    = bst_pkg::BSR_W
) (
  // clock and reset
  input  wire logic                   core_clk_i,
  input  wire logic                   rstn_i,
  // serial test pins
  input  wire logic                   test_serial_clock_i,
  input  wire logic                   test_serial_in_i,
  output logic                        test_serial_out_o,
  output logic                        test_serial_out_oe_o,
  // tap controller and current instruction
  input  wire bst_pkg::bst_tap_s      tap_i,
  input  wire bst_pkg::bst_instr_t    instr_i,
  // functional pins seen by the boundary cells
  input  wire logic [BSR_W-1:0]       pin_sample_i,
  input  wire logic [BSR_W-1:0]       func_out_i,
  input  wire logic [BSR_W-1:0]       func_oe_i,
  output logic      [BSR_W-1:0]       pin_out_o,
  output logic      [BSR_W-1:0]       pin_oe_o,
  // latched parallel outputs
  output logic [bst_pkg::ID_W-1:0]    id_par_o,
  output logic      [BSR_W-1:0]       bsr_par_o
);

  localparam int IDW = bst_pkg::ID_W;

  // lsb forced to one whatever the maker field holds
  localparam logic [IDW-1:0] ID_CODE = {ID_REV, ID_PART,
                                        ID_MAKER[11:1], 1'h1};

  initial
  begin
    if (BSR_W < 1) $error("bst_tdr: BSR_W must be at least one");
    if (IDW != bst_pkg::ID_REV_W + bst_pkg::ID_PART_W + bst_pkg::ID_MAKER_W)
      $error("bst_tdr: id fields do not fill the id register");
  end

  // filtered test clock and data level
  logic [1:0] pin_f;
  logic       tck_q;                    // previous filtered clock level
  logic       tck_rise, tck_fall;
  logic       tdi;

  bst_pin_sync #(.W(2)) u_sync (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .d_i        ({test_serial_clock_i, test_serial_in_i}),
    .q_o        (pin_f)
  );

  assign tdi      = pin_f[0];
  assign tck_rise = pin_f[1] & ~tck_q;
  assign tck_fall = ~pin_f[1] & tck_q;

  // register selection from instruction and tap state
  bst_pkg::bst_sel_e sel;
  logic              drive_bsr;          // extest or clamp
  logic              highz;

  always_comb
  begin
    case (instr_i)
      bst_pkg::INS_IDCODE: sel = bst_pkg::SEL_ID;
      bst_pkg::INS_EXTEST: sel = bst_pkg::SEL_BSR;
      bst_pkg::INS_SAMPLE: sel = bst_pkg::SEL_BSR;
      bst_pkg::INS_BYPASS: sel = bst_pkg::SEL_BYP;
      bst_pkg::INS_CLAMP:  sel = bst_pkg::SEL_BYP;
      bst_pkg::INS_HIGHZ:  sel = bst_pkg::SEL_BYP;
      default:             sel = bst_pkg::SEL_BYP; // unused codes bypass
    endcase
    if (tap_i.tlr) sel = bst_pkg::SEL_ID;
    drive_bsr = (instr_i == bst_pkg::INS_EXTEST) ||
                (instr_i == bst_pkg::INS_CLAMP);
    highz     = (instr_i == bst_pkg::INS_HIGHZ);
  end

  // shift and latch stages
  logic             byp, next_byp;
  logic [IDW-1:0]   id_sh, next_id_sh;
  logic [IDW-1:0]   next_id_par;
  logic [BSR_W-1:0] bsr_sh, next_bsr_sh;
  logic [BSR_W-1:0] next_bsr_par;
  logic             next_tdo, next_tdo_oe;
  logic [BSR_W-1:0] next_pin_out, next_pin_oe;

  // next values: capture and shift on test clock rise, latch on fall
  always_comb
  begin
    next_byp     = byp;
    next_id_sh   = id_sh;
    next_bsr_sh  = bsr_sh;
    next_id_par  = id_par_o;
    next_bsr_par = bsr_par_o;
    next_tdo     = test_serial_out_o;
    next_tdo_oe  = test_serial_out_oe_o;
    if (tck_rise && tap_i.capture_dr)
    begin
      case (sel)
        bst_pkg::SEL_ID:  next_id_sh  = ID_CODE;
        bst_pkg::SEL_BSR: next_bsr_sh = pin_sample_i;
        bst_pkg::SEL_BYP: next_byp    = 1'h0;
        default:          next_byp    = 1'h0;
      endcase
    end
    else if (tck_rise && tap_i.shift_dr)
    begin
      // lsb leaves first, new data enters at the top
      case (sel)
        bst_pkg::SEL_ID:  next_id_sh  = {tdi, id_sh[IDW-1:1]};
        bst_pkg::SEL_BSR: next_bsr_sh = {tdi, bsr_sh[BSR_W-1:1]};
        bst_pkg::SEL_BYP: next_byp    = tdi;
        default:          next_byp    = tdi;
      endcase
    end
    if (tck_fall)
    begin
      // output changes on the falling edge so the tester samples on rise
      next_tdo_oe = tap_i.shift_dr;
      case (sel)
        bst_pkg::SEL_ID:  next_tdo = id_sh[0];
        bst_pkg::SEL_BSR: next_tdo = bsr_sh[0];
        bst_pkg::SEL_BYP: next_tdo = byp;
        default:          next_tdo = byp;
      endcase
      if (tap_i.tlr)
        next_id_par = ID_CODE;
      else if (tap_i.update_dr && sel == bst_pkg::SEL_ID)
        next_id_par = id_sh;
      // clamp keeps the latch frozen since boundary is not selected
      if (tap_i.update_dr && sel == bst_pkg::SEL_BSR)
        next_bsr_par = bsr_sh;
    end
    // pin steering, registered so outputs come from flops
    if (highz)
    begin
      next_pin_out = func_out_i;
      next_pin_oe  = '0;
    end
    else if (drive_bsr)
    begin
      next_pin_out = bsr_par_o;
      next_pin_oe  = '1;
    end
    else
    begin
      next_pin_out = func_out_i;
      next_pin_oe  = func_oe_i;
    end
  end

  // register stage for all test data state
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      tck_q                <= 1'h0;
      byp                  <= bst_pkg::BYP_RST;
      id_sh                <= '0;
      bsr_sh               <= '0;
      id_par_o             <= '0;
      bsr_par_o            <= '0;
      test_serial_out_o    <= bst_pkg::TDO_RST;
      test_serial_out_oe_o <= 1'h0;
      pin_out_o            <= '0;
      pin_oe_o             <= '0;
    end
    else
    begin
      tck_q                <= pin_f[1];
      byp                  <= next_byp;
      id_sh                <= next_id_sh;
      bsr_sh               <= next_bsr_sh;
      id_par_o             <= next_id_par;
      bsr_par_o            <= next_bsr_par;
      test_serial_out_o    <= next_tdo;
      test_serial_out_oe_o <= next_tdo_oe;
      pin_out_o            <= next_pin_out;
      pin_oe_o             <= next_pin_oe;
    end
  end

  // checks
  sequence s_id_capture;
    tck_rise && tap_i.capture_dr && sel == bst_pkg::SEL_ID;
  endsequence

  property p_byp_zero;
    @(posedge core_clk_i) disable iff (!rstn_i)
    tck_rise && tap_i.capture_dr && sel == bst_pkg::SEL_BYP |=> byp == 1'h0;
  endproperty
  a_byp_zero: assert property (p_byp_zero)
    else $error("bypass stage did not capture zero");

  property p_byp_shift;
    @(posedge core_clk_i) disable iff (!rstn_i)
    tck_rise && tap_i.shift_dr && !tap_i.capture_dr &&
    sel == bst_pkg::SEL_BYP |=> byp == $past(tdi);
  endproperty
  a_byp_shift: assert property (p_byp_shift)
    else $error("bypass stage did not take serial input");

  property p_tlr_sel;
    @(posedge core_clk_i) disable iff (!rstn_i)
    tap_i.tlr |-> sel == bst_pkg::SEL_ID;
  endproperty
  a_tlr_sel: assert property (p_tlr_sel)
    else $error("reset state did not select id register");

  property p_id_load;
    @(posedge core_clk_i) disable iff (!rstn_i)
    s_id_capture |=> id_sh == ID_CODE && id_sh[0];
  endproperty
  a_id_load: assert property (p_id_load)
    else $error("id code not loaded at capture");

  property p_id_shift;
    @(posedge core_clk_i) disable iff (!rstn_i)
    tck_rise && tap_i.shift_dr && !tap_i.capture_dr &&
    sel == bst_pkg::SEL_ID |=> id_sh == {$past(tdi), $past(id_sh[IDW-1:1])};
  endproperty
  a_id_shift: assert property (p_id_shift)
    else $error("id register did not shift");

  property p_tlr_par;
    @(posedge core_clk_i) disable iff (!rstn_i)
    tck_fall && tap_i.tlr |=> id_par_o == ID_CODE && id_par_o[0] == 1'h1;
  endproperty
  a_tlr_par: assert property (p_tlr_par)
    else $error("id parallel output not forced in reset state");

  property p_bsr_latch;
    @(posedge core_clk_i) disable iff (!rstn_i)
    tck_fall && tap_i.update_dr && sel == bst_pkg::SEL_BSR
    |=> bsr_par_o == $past(bsr_sh);
  endproperty
  a_bsr_latch: assert property (p_bsr_latch)
    else $error("boundary latch not updated");

  property p_highz;
    @(posedge core_clk_i) disable iff (!rstn_i)
    instr_i == bst_pkg::INS_HIGHZ |=> pin_oe_o == '0;
  endproperty
  a_highz: assert property (p_highz)
    else $error("outputs not floated under highz");

  property p_clamp;
    @(posedge core_clk_i) disable iff (!rstn_i)
    instr_i == bst_pkg::INS_CLAMP |=> pin_out_o == $past(bsr_par_o) &&
                                      pin_oe_o == '1;
  endproperty
  a_clamp: assert property (p_clamp)
    else $error("outputs not clamped to latch values");

  property p_bypass_code;
    @(posedge core_clk_i) disable iff (!rstn_i)
    instr_i == bst_pkg::INS_BYPASS && !tap_i.tlr |-> sel == bst_pkg::SEL_BYP;
  endproperty
  a_bypass_code: assert property (p_bypass_code)
    else $error("bypass code did not select bypass stage");

endmodule

// ===== bst_tester.sv
`timescale 1ns/10ps
// far-side stand-in: boundary-scan tester plus the tap state flags
module bst_tester (
  // core clock, only used to pace the tester
  input  wire logic              core_clk_i,
  // serial test pins
  output logic                   test_serial_clock_o,
  output logic                   test_serial_in_o,
  input  wire logic              test_serial_out_i,
  input  wire logic              test_serial_out_oe_i,
  // tap controller flags as the device would see them
  output bst_pkg::bst_tap_s      tap_o
);
  // idle pins at time zero; test clock stands low outside frames
  initial
  begin
    test_serial_clock_o = 1'h0;
    test_serial_in_o    = 1'h0;
    tap_o               = '0;
  end

  // one 200 ns test clock period (8 core cycles); the tap moves after
  // the fall, so the synchronised fall lands in the next state as a real tap does
  task automatic pulse(input logic d, input bst_pkg::bst_tap_s nxt,
                       output logic q, output logic qe);
    test_serial_in_o = d;
    repeat (2) @(negedge core_clk_i);
    test_serial_clock_o = 1'h1;
    repeat (3) @(negedge core_clk_i);
    // read late in the high phase: output from the previous fall
    q  = test_serial_out_i;
    qe = test_serial_out_oe_i;
    @(negedge core_clk_i);
    test_serial_clock_o = 1'h0;
    @(negedge core_clk_i);
    tap_o = nxt;
    @(negedge core_clk_i);
  endtask

  // full data scan from idle: select, capture, n shifts, exit, update
  task automatic scan(input int n, input logic [63:0] din,
                      output logic [63:0] dout, output logic oe_ok);
    logic q;
    logic qe;
    dout  = '0;
    oe_ok = 1'h1;
    pulse(1'h0, 4'h0, q, qe);          // idle to select
    pulse(1'h0, 4'h4, q, qe);          // select to capture
    pulse(1'h0, 4'h2, q, qe);          // capture to shift
    for (int k = 0; k < n; k++)
    begin
      // lsb first; the last shift leaves for exit
      pulse(din[k], (k == n - 1) ? 4'h0 : 4'h2, q, qe);
      dout[k] = q;
      oe_ok   = oe_ok & qe;
    end
    pulse(~din[n-1], 4'h1, q, qe);     // exit to update
    oe_ok = oe_ok & ~qe;               // output released after shift
    pulse(~q, 4'h0, q, qe);            // update to idle; the latch took place on the previous fall
    // released data line shows the inverse, not a stale value
    test_serial_in_o = ~test_serial_in_o;
    // let an edge pass so a following call never reassigns it at once
    @(negedge core_clk_i);
  endtask
endmodule

// ===== bst_tdr_tb.sv
`timescale 1ns/10ps
// self-checking bench for the test data registers
module bst_tdr_tb;
  // arbitrary identity values; maker lsb left zero on purpose
  localparam logic [3:0]  P_REV   = 4'hA;
  localparam logic [15:0] P_PART  = 16'h5A3C;
  localparam logic [11:0] P_MAKER = 12'h2B4;
  localparam logic [31:0] CODE    = {P_REV, P_PART, P_MAKER[11:1], 1'h1};
  localparam logic [31:0] PINS    = 32'hC3A5_0F96;

  logic                core_clk_i;
  logic                rstn_i;
  logic                tck;
  logic                tdi;
  logic                tdo;
  logic                tdo_oe;
  bst_pkg::bst_tap_s   tap;
  bst_pkg::bst_instr_t instr;
  logic [31:0]         pin_sample;
  logic [31:0]         func_out;
  logic [31:0]         func_oe;
  logic [31:0]         pin_out;
  logic [31:0]         pin_oe;
  logic [31:0]         id_par;
  logic [31:0]         bsr_par;
  logic [63:0]         d;
  logic                ok;
  int                  miscompares;
  int                  checks;

  bst_tdr #(.ID_REV(P_REV), .ID_PART(P_PART), .ID_MAKER(P_MAKER)) i_dut (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i),
    .test_serial_clock_i(tck), .test_serial_in_i(tdi),
    .test_serial_out_o(tdo), .test_serial_out_oe_o(tdo_oe),
    .tap_i(tap), .instr_i(instr), .pin_sample_i(pin_sample),
    .func_out_i(func_out), .func_oe_i(func_oe), .pin_out_o(pin_out),
    .pin_oe_o(pin_oe), .id_par_o(id_par), .bsr_par_o(bsr_par));

  bst_tester i_tester (
    .core_clk_i(core_clk_i), .test_serial_clock_o(tck),
    .test_serial_in_o(tdi), .test_serial_out_i(tdo),
    .test_serial_out_oe_i(tdo_oe), .tap_o(tap));

  // 40 MHz core clock
  initial
  begin
    core_clk_i = 1'h0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  // compare and count; four-state equality so unknowns fail
  task automatic check(input logic [63:0] got, exp, input string what);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask

  // single place that ends the run
  task automatic end_of_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // id capture, shift, latch, and forced load in reset state
  task automatic t_idcode();
    logic q;
    logic qe;
    instr = bst_pkg::INS_IDCODE;
    i_tester.scan(32, 64'h0F0F_1234, d, ok);
    check(d[31:0], CODE, "id code shifted out");
    check(ok, 1'h1, "tdo enable during shift");
    check(id_par, 32'h0F0F_1234, "id latch");
    i_tester.pulse(1'h0, 4'h8, q, qe);
    i_tester.pulse(1'h0, 4'h0, q, qe);
    check(id_par, CODE, "id forced in reset state");
    $display("test idcode done");
  endtask

  // every bypass-path code: one stage, captures zero
  task automatic t_bypass();
    bst_pkg::bst_instr_t codes [5];
    codes = '{bst_pkg::INS_BYPASS, bst_pkg::INS_CLAMP,
              bst_pkg::INS_HIGHZ, 3'h5, 3'h6};
    for (int i = 0; i < 5; i++)
    begin
      instr = codes[i];
      i_tester.scan(8, 64'hB4, d, ok);
      check(d[7:0], 8'h68, "one-bit delay path");
    end
    $display("test bypass done");
  endtask

  // boundary register: sample, length, extest, clamp, highz
  task automatic t_bsr();
    instr = bst_pkg::INS_SAMPLE;
    i_tester.scan(32, 64'h1234_5678, d, ok);
    check(d[31:0], PINS, "pins sampled");
    check(bsr_par, 32'h1234_5678, "preload latch");
    check(pin_out, func_out, "sample leaves pins");
    check(pin_oe, func_oe, "sample leaves enables");
    instr = bst_pkg::INS_EXTEST;
    i_tester.scan(40, 64'h3C_9ABC_DEF0, d, ok);
    check(d[39:32], 8'hF0, "boundary length 32");
    check(bsr_par, 32'h3C9A_BCDE, "extest latch");
    check(pin_out, 32'h3C9A_BCDE, "extest drive");
    instr = bst_pkg::INS_CLAMP;
    i_tester.scan(8, 64'h55, d, ok);
    check(bsr_par, 32'h3C9A_BCDE, "clamp freezes");
    check(pin_out, 32'h3C9A_BCDE, "clamp holds");
    check(pin_oe, 32'hFFFF_FFFF, "clamp drives");
    instr = bst_pkg::INS_HIGHZ;
    repeat (3) @(negedge core_clk_i);
    check(pin_oe, 32'h0, "highz floats");
    $display("test boundary done");
  endtask

  // watchdog: every wait is a fixed count, this cuts any hang
  initial
  begin
    repeat (20000) @(posedge core_clk_i);
    miscompares++;
    end_of_test();
  end

  // main sequence
  initial
  begin
    miscompares = 0;
    checks      = 0;
    rstn_i      = 1'h0;
    instr       = bst_pkg::INS_BYPASS;
    pin_sample  = PINS;
    func_out    = 32'h0000_FFFF;
    func_oe     = 32'h00FF_00FF;
    repeat (12) @(negedge core_clk_i);
    check(tdo_oe, 1'h0, "tdo idle in reset");
    rstn_i = 1'h1;
    repeat (6) @(negedge core_clk_i);
    t_idcode();
    t_bypass();
    t_bsr();
    end_of_test();
  end
endmodule
